//--- rtl/ansc_params.svh
// Behaviour
// - At reset, sample both straps; set negotiation status bit and abilities 8:5.
// - Each strap decodes to low, mid or high from two comparator outputs.
// - Upper low, lower mid: force 10 half; status 0,1,0; advertise 021h.
// - Upper high, lower mid: force 10 full; status 0,1,1; advertise 041h.
// - Upper mid, lower low: force 100 half; status 0,0,0; advertise 081h.
// - Upper mid, lower high: force 100 full; status 0,0,1; advertise 101h.
// - Both mid: negotiate, advertise all four abilities, 1E1h.
// - Both low: negotiate, advertise 10 half and full, 061h.
// - Upper low, lower high: negotiate, advertise 100 half and full, 181h.
// - Upper high, lower low: negotiate, advertise 10 and 100 half, 0A1h.
// - Both high: negotiate, advertise 10 half only, 021h.
// - While negotiating, send the held advertisement to the partner in bursts.
// - Advertisement accepts any combination of ability bits written by software.
// - Straps never change basic control; software writes change negotiation once straps are captured.
// - Basic control does not show strap mode; read status and advertisement.
// - Resolve highest common ability: 100F, 100H, 10F, 10H.
// - Forced: control bit 13 speed, bit 8 duplex; taken only from the write that clears bit 12.
// - Control bit 9, written with bit 12 set, restarts negotiation; losing link in negotiated mode resumes it.
`ifndef ANSC_PARAMS_SVH
`define ANSC_PARAMS_SVH
`define ANSC_OFS_CTRL     8'h00
`define ANSC_OFS_ADV      8'h04
`define ANSC_OFS_PARTNER  8'h05
`define ANSC_OFS_STATUS   8'h10
`define ANSC_CTRL_RESET   16'h0000
`define ANSC_ADV_10H_FRC  16'h0021
`define ANSC_ADV_10F_FRC  16'h0041
`define ANSC_ADV_100H_FRC 16'h0081
`define ANSC_ADV_100F_FRC 16'h0101
`define ANSC_ADV_ALL      16'h01e1
`define ANSC_ADV_10_BOTH  16'h0061
`define ANSC_ADV_100_BOTH 16'h0181
`define ANSC_ADV_HALF     16'h00a1
`define ANSC_ADV_10H_ONLY 16'h0021
`define ANSC_ADV_WR_MASK  16'h01e0
`define ANSC_SELECTOR     16'h0001
`define ANSC_CB_SPEED     13
`define ANSC_CB_AN_EN     12
`define ANSC_CB_RESTART   9
`define ANSC_CB_DUPLEX    8
`define ANSC_SB_AN_EN     9
`define ANSC_SB_AN_DONE   4
`define ANSC_SB_FULL      2
`define ANSC_SB_SPEED10   1
`define ANSC_SB_LINK      0
`define ANSC_AB_10H       5
`define ANSC_AB_10F       6
`define ANSC_AB_100H      7
`define ANSC_AB_100F      8
`define ANSC_CLK_HZ       20000000
`define ANSC_BURST_US     16000
`define ANSC_BURST_CYC    ((`ANSC_CLK_HZ / 1000000) * `ANSC_BURST_US)
`endif

//--- rtl/ansc_pkg.sv
package ansc_pkg;
  typedef enum logic [1:0] {ANSC_LVL_LOW, ANSC_LVL_MID, ANSC_LVL_HIGH} ansc_level_t;
  typedef enum logic [2:0] {ANSC_RES_NONE, ANSC_RES_10H, ANSC_RES_10F,
                            ANSC_RES_100H, ANSC_RES_100F} ansc_res_t;
endpackage

//--- rtl/ansc_strap_decode.sv
`timescale 1ns/1ns
module ansc_strap_decode (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               cmp_a,
  input  wire logic               cmp_b,
  output ansc_pkg::ansc_level_t   level
);
  logic meta_a_reg, meta_b_reg, sync_a_reg, sync_b_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_a_reg <= 1'b0;
      meta_b_reg <= 1'b0;
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
    end else begin
      meta_a_reg <= cmp_a;
      meta_b_reg <= cmp_b;
      sync_a_reg <= meta_a_reg;
      sync_b_reg <= meta_b_reg;
    end
  end
  // Invalid high/low pair treated as mid, the pin's floating default
  always_comb begin
    if (!sync_a_reg && !sync_b_reg)
      level = ansc_pkg::ANSC_LVL_LOW;
    else if (sync_a_reg && sync_b_reg)
      level = ansc_pkg::ANSC_LVL_HIGH;
    else
      level = ansc_pkg::ANSC_LVL_MID;
  end
endmodule

//--- rtl/ansc_top.sv
`timescale 1ns/1ns
`include "ansc_params.svh"
module ansc_top #(
  parameter int BURST_CYC = `ANSC_BURST_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        strap_select_low_a,
  input  wire logic        strap_select_low_b,
  input  wire logic        strap_select_high_a,
  input  wire logic        strap_select_high_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] partner_abilities,
  input  wire logic        partner_valid,
  input  wire logic        link_ok,
  output logic             burst_send,
  output logic      [15:0] burst_word,
  output logic             speed_100,
  output logic             full_duplex
);
  ansc_pkg::ansc_level_t lvl_low, lvl_high;

  ansc_strap_decode u_dec_low (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cmp_a   (strap_select_low_a),
    .cmp_b   (strap_select_low_b),
    .level   (lvl_low)
  );
  ansc_strap_decode u_dec_high (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cmp_a   (strap_select_high_a),
    .cmp_b   (strap_select_high_b),
    .level   (lvl_high)
  );

  // Straps settle through the two-stage synchronisers before capture
  logic [1:0]  settle_reg, settle_next;
  logic        captured_reg, captured_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] adv_reg, adv_next;
  logic [15:0] partner_reg, partner_next;
  logic        strap_an_reg, strap_an_next;
  logic        strap_s10_reg, strap_s10_next;
  logic        strap_full_reg, strap_full_next;
  logic        an_active_reg, an_active_next;
  logic        an_done_reg, an_done_next;
  logic        an_en_prev_reg, an_en_prev_next;
  logic        speed_100_reg, speed_100_next;
  logic        full_reg, full_next;
  logic [31:0] burst_cnt_reg, burst_cnt_next;
  logic        burst_reg, burst_next;
  logic [15:0] burst_word_reg, burst_word_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] status_val;
  logic [15:0] common;
  ansc_pkg::ansc_res_t res;

  always_comb begin
    common = adv_reg & partner_reg;
    if (common[`ANSC_AB_100F])
      res = ansc_pkg::ANSC_RES_100F;
    else if (common[`ANSC_AB_100H])
      res = ansc_pkg::ANSC_RES_100H;
    else if (common[`ANSC_AB_10F])
      res = ansc_pkg::ANSC_RES_10F;
    else if (common[`ANSC_AB_10H])
      res = ansc_pkg::ANSC_RES_10H;
    else
      res = ansc_pkg::ANSC_RES_NONE;
  end

  // Status bits 9, 4, 2, 1, 0; speed/duplex only trusted when forced or done
  always_comb begin
    status_val                   = 16'h0000;
    status_val[`ANSC_SB_AN_EN]   = strap_an_reg;
    status_val[`ANSC_SB_AN_DONE] = an_done_reg;
    status_val[`ANSC_SB_FULL]    = full_reg;
    status_val[`ANSC_SB_SPEED10] = ~speed_100_reg;
    status_val[`ANSC_SB_LINK]    = link_ok;
  end

  always_comb begin
    settle_next     = settle_reg;
    captured_next   = captured_reg;
    ctrl_next       = ctrl_reg;
    adv_next        = adv_reg;
    partner_next    = partner_reg;
    strap_an_next   = strap_an_reg;
    strap_s10_next  = strap_s10_reg;
    strap_full_next = strap_full_reg;
    an_active_next  = an_active_reg;
    an_done_next    = an_done_reg;
    an_en_prev_next = ctrl_reg[`ANSC_CB_AN_EN];
    speed_100_next  = speed_100_reg;
    full_next       = full_reg;
    burst_cnt_next  = burst_cnt_reg;
    burst_next      = 1'b0;
    burst_word_next = burst_word_reg;
    rdata_next      = rdata_reg;

    if (!captured_reg) begin
      // One-time strap capture after reset release
      if (settle_reg != 2'd3) begin
        settle_next = settle_reg + 2'd1;
      end else begin
        captured_next = 1'b1;
        strap_an_next = 1'b1;
        strap_s10_next = 1'b0;
        strap_full_next = 1'b0;
        case ({lvl_high, lvl_low})
          {ansc_pkg::ANSC_LVL_LOW, ansc_pkg::ANSC_LVL_MID}: begin
            adv_next = `ANSC_ADV_10H_FRC;
            strap_an_next = 1'b0;
            strap_s10_next = 1'b1;
          end
          {ansc_pkg::ANSC_LVL_HIGH, ansc_pkg::ANSC_LVL_MID}: begin
            adv_next = `ANSC_ADV_10F_FRC;
            strap_an_next = 1'b0;
            strap_s10_next = 1'b1;
            strap_full_next = 1'b1;
          end
          {ansc_pkg::ANSC_LVL_MID, ansc_pkg::ANSC_LVL_LOW}: begin
            adv_next = `ANSC_ADV_100H_FRC;
            strap_an_next = 1'b0;
          end
          {ansc_pkg::ANSC_LVL_MID, ansc_pkg::ANSC_LVL_HIGH}: begin
            adv_next = `ANSC_ADV_100F_FRC;
            strap_an_next = 1'b0;
            strap_full_next = 1'b1;
          end
          {ansc_pkg::ANSC_LVL_MID, ansc_pkg::ANSC_LVL_MID}: begin
            adv_next = `ANSC_ADV_ALL;
          end
          {ansc_pkg::ANSC_LVL_LOW, ansc_pkg::ANSC_LVL_LOW}: begin
            adv_next = `ANSC_ADV_10_BOTH;
          end
          {ansc_pkg::ANSC_LVL_LOW, ansc_pkg::ANSC_LVL_HIGH}: begin
            adv_next = `ANSC_ADV_100_BOTH;
          end
          {ansc_pkg::ANSC_LVL_HIGH, ansc_pkg::ANSC_LVL_LOW}: begin
            adv_next = `ANSC_ADV_HALF;
          end
          {ansc_pkg::ANSC_LVL_HIGH, ansc_pkg::ANSC_LVL_HIGH}: begin
            adv_next = `ANSC_ADV_10H_ONLY;
          end
          default: begin
            adv_next = `ANSC_ADV_ALL;
          end
        endcase
        an_active_next = strap_an_next;
        speed_100_next = ~strap_s10_next;
        full_next = strap_full_next;
      end
    end else begin
      // Negotiated or forced mode follows control once software sets it
      if (ctrl_reg[`ANSC_CB_AN_EN] && !an_en_prev_reg) begin
        an_active_next = 1'b1;
        an_done_next = 1'b0;
      end else if (!ctrl_reg[`ANSC_CB_AN_EN] && an_en_prev_reg) begin
        an_active_next = 1'b0;
        an_done_next = 1'b0;
      end
      if (an_active_reg && !an_done_reg) begin
        if (burst_cnt_reg >= BURST_CYC - 1) begin
          burst_cnt_next = 32'd0;
          burst_next = 1'b1;
          burst_word_next = adv_reg;
        end else begin
          burst_cnt_next = burst_cnt_reg + 32'd1;
        end
        if (partner_valid) begin
          partner_next = partner_abilities;
        end
        // Judge the fresh word; partner_reg still holds the previous exchange
        if (partner_valid && link_ok &&
            (adv_reg & partner_abilities & `ANSC_ADV_WR_MASK) != 16'h0000) begin
          an_done_next = 1'b1;
        end
      end
      if (an_done_reg) begin
        speed_100_next = (res == ansc_pkg::ANSC_RES_100F) ||
                         (res == ansc_pkg::ANSC_RES_100H);
        full_next = (res == ansc_pkg::ANSC_RES_100F) ||
                    (res == ansc_pkg::ANSC_RES_10F);
        if (!link_ok) begin
          an_done_next = 1'b0;
          burst_cnt_next = 32'd0;
        end
      end
      // Forced values come last so a resolved mode still held cannot override them
      if (!ctrl_reg[`ANSC_CB_AN_EN] && an_en_prev_reg) begin
        speed_100_next = ctrl_reg[`ANSC_CB_SPEED];
        full_next = ctrl_reg[`ANSC_CB_DUPLEX];
      end
    end

    if (reg_wr && captured_reg) begin
      case (reg_addr)
        `ANSC_OFS_CTRL: begin
          ctrl_next = reg_wdata;
          ctrl_next[`ANSC_CB_RESTART] = 1'b0;
          if (reg_wdata[`ANSC_CB_RESTART] && reg_wdata[`ANSC_CB_AN_EN]) begin
            an_active_next = 1'b1;
            an_done_next = 1'b0;
            burst_cnt_next = 32'd0;
          end
        end
        `ANSC_OFS_ADV: begin
          adv_next = (reg_wdata & `ANSC_ADV_WR_MASK) | `ANSC_SELECTOR;
        end
        default: begin
        end
      endcase
    end

    rdata_next = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `ANSC_OFS_CTRL:    rdata_next = ctrl_reg;
        `ANSC_OFS_ADV:     rdata_next = adv_reg;
        `ANSC_OFS_PARTNER: rdata_next = partner_reg;
        `ANSC_OFS_STATUS:  rdata_next = status_val;
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg     <= 2'd0;
      captured_reg   <= 1'b0;
      ctrl_reg       <= `ANSC_CTRL_RESET;
      adv_reg        <= `ANSC_ADV_ALL;
      partner_reg    <= 16'h0000;
      strap_an_reg   <= 1'b0;
      strap_s10_reg  <= 1'b0;
      strap_full_reg <= 1'b0;
      an_active_reg  <= 1'b0;
      an_done_reg    <= 1'b0;
      an_en_prev_reg <= 1'b0;
      speed_100_reg  <= 1'b0;
      full_reg       <= 1'b0;
      burst_cnt_reg  <= 32'd0;
      burst_reg      <= 1'b0;
      burst_word_reg <= 16'h0000;
      rdata_reg      <= 16'h0000;
    end else begin
      settle_reg     <= settle_next;
      captured_reg   <= captured_next;
      ctrl_reg       <= ctrl_next;
      adv_reg        <= adv_next;
      partner_reg    <= partner_next;
      strap_an_reg   <= strap_an_next;
      strap_s10_reg  <= strap_s10_next;
      strap_full_reg <= strap_full_next;
      an_active_reg  <= an_active_next;
      an_done_reg    <= an_done_next;
      an_en_prev_reg <= an_en_prev_next;
      speed_100_reg  <= speed_100_next;
      full_reg       <= full_next;
      burst_cnt_reg  <= burst_cnt_next;
      burst_reg      <= burst_next;
      burst_word_reg <= burst_word_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign reg_rdata   = rdata_reg;
  assign burst_send  = burst_reg;
  assign burst_word  = burst_word_reg;
  assign speed_100   = speed_100_reg;
  assign full_duplex = full_reg;
endmodule

//--- verif/ansc_asserts.sv
`timescale 1ns/1ns
module ansc_asserts #(
  parameter int BURST_CYC = 8
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        burst_send,
  input wire logic [15:0] burst_word,
  input wire logic        speed_100,
  input wire logic        full_duplex
);
  // Last control write: enable, falling-enable pulse, speed, duplex
  logic [3:0] hold_reg;
  logic [3:0] hold_next;
  always_comb begin
    hold_next = hold_reg;
    hold_next[2] = 1'b0;
    if (reg_wr && reg_addr == 8'h00) begin
      hold_next = {reg_wdata[12], hold_reg[3] & ~reg_wdata[12], reg_wdata[13], reg_wdata[8]};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 4'h0;
    end else begin
      hold_reg <= hold_next;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_quiet_capture: assert property ($rose(rst_n) |-> !burst_send [*4])
    else $error("burst before strap capture");
  a_burst_pulse: assert property (burst_send |=> !burst_send)
    else $error("burst strobe longer than one cycle");
  a_burst_form: assert property (burst_send |=> burst_word[4:0] == 5'h01 && burst_word[15:9] == 7'h00)
    else $error("burst word malformed");
  a_adv_selector: assert property ($past(reg_rd) && $past(reg_addr) == 8'h04
    |-> reg_rdata[4:0] == 5'h01 && reg_rdata[15:9] == 7'h00)
    else $error("advertisement selector wrong");
  a_adv_write_back: assert property (reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04
    |=> reg_rdata == (($past(reg_wdata, 2) & 16'h01e0) | 16'h0001))
    else $error("advertisement write lost");
  a_ctrl_write_back: assert property (reg_wr && reg_addr == 8'h00 ##1 reg_rd && reg_addr == 8'h00
    |=> (reg_rdata & 16'h3100) == ($past(reg_wdata, 2) & 16'h3100))
    else $error("control write lost");
  a_restart_clear: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> !reg_rdata[9])
    else $error("restart bit not self clearing");
  a_forced_follow: assert property (hold_reg[2]
    |-> ##[0:3] (speed_100 == hold_reg[1] && full_duplex == hold_reg[0]))
    else $error("forced mode not applied");
endmodule
bind ansc_top ansc_asserts #(.BURST_CYC(BURST_CYC)) i_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .burst_send(burst_send),
  .burst_word(burst_word), .speed_100(speed_100), .full_duplex(full_duplex));

//--- verif/ansc_link_partner.sv
`timescale 1ns/1ns
module ansc_link_partner (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        burst_send,
  input  wire logic [15:0] burst_word,
  input  wire logic        cfg_on,
  input  wire logic        cfg_link,
  input  wire logic [15:0] cfg_word,
  input  wire logic [3:0]  cfg_lag,
  output logic      [15:0] heard_word,
  output logic      [15:0] partner_abilities,
  output logic             partner_valid,
  output logic             link_ok
);
  logic [3:0] lag_cnt;
  logic       heard;
  assign link_ok = cfg_link;
  // Unreleased word shows the inverse so a stale value never passes
  assign partner_abilities = partner_valid ? cfg_word : ~cfg_word;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lag_cnt <= 4'h0;
      heard <= 1'b0;
      heard_word <= 16'h0000;
      partner_valid <= 1'b0;
    end else if (!cfg_on || !cfg_link) begin
      lag_cnt <= 4'h0;
      heard <= 1'b0;
      partner_valid <= 1'b0;
    end else if (burst_send && !heard) begin
      heard <= 1'b1;
      heard_word <= burst_word;
    end else if (heard && lag_cnt < cfg_lag) begin
      lag_cnt <= lag_cnt + 4'h1;
    end else if (heard) begin
      partner_valid <= 1'b1;
    end
  end
endmodule

//--- verif/test_autoneg_strap_config.sv
`timescale 1ns/1ns
`include "ansc_params.svh"
module test_autoneg_strap_config;
  logic        ref_clk;
  logic        rst_n;
  logic [1:0]  lo_pins;
  logic [1:0]  hi_pins;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] p_word;
  logic        p_valid;
  logic        link_ok;
  logic        burst_send;
  logic [15:0] burst_word;
  logic        speed_100;
  logic        full_duplex;
  logic        cfg_on;
  logic        cfg_link;
  logic [15:0] cfg_word;
  logic [3:0]  cfg_lag;
  logic [15:0] heard_word;
  logic [15:0] rd_val;
  int          n_fail;
  int          comparisons;
  int          hi_t[9] = '{0, 2, 1, 1, 1, 0, 0, 2, 2};
  int          lo_t[9] = '{1, 1, 0, 2, 1, 0, 2, 0, 2};
  logic [15:0] adv_t[9] = '{16'h0021, 16'h0041, 16'h0081, 16'h0101, 16'h01e1,
                            16'h0061, 16'h0181, 16'h00a1, 16'h0021};
  logic [15:0] st_t[9] = '{16'h0002, 16'h0006, 16'h0000, 16'h0004, 16'h0200,
                           16'h0200, 16'h0200, 16'h0200, 16'h0200};
  ansc_top #(.BURST_CYC(8)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .strap_select_low_a(lo_pins[1]),
    .strap_select_low_b(lo_pins[0]), .strap_select_high_a(hi_pins[1]),
    .strap_select_high_b(hi_pins[0]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .partner_abilities(p_word),
    .partner_valid(p_valid), .link_ok(link_ok), .burst_send(burst_send),
    .burst_word(burst_word), .speed_100(speed_100), .full_duplex(full_duplex));
  ansc_link_partner i_partner (
    .ref_clk(ref_clk), .rst_n(rst_n), .burst_send(burst_send), .burst_word(burst_word),
    .cfg_on(cfg_on), .cfg_link(cfg_link), .cfg_word(cfg_word), .cfg_lag(cfg_lag),
    .heard_word(heard_word), .partner_abilities(p_word), .partner_valid(p_valid),
    .link_ok(link_ok));
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = reg_rdata;
    @(posedge ref_clk);
  endtask
  function automatic logic [1:0] pins(input int l);
    return l == 0 ? 2'b00 : (l == 1 ? 2'b01 : 2'b11);
  endfunction
  task automatic restart_dut(input int hi, input int lo);
    hi_pins <= pins(hi);
    lo_pins <= pins(lo);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    // Pass an edge first; a flag still held from the last exchange (no link drop between) ends the wait at once
    do begin
      @(posedge ref_clk);
      k++;
    end while (k < 200 && p_valid !== 1'b1);
    if (p_valid !== 1'b1) begin
      n_fail++;
      $display("Error at %0t ns: partner never answered", $time);
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_straps();
    int n;
    for (int i = 0; i < 9; i++) begin
      restart_dut(hi_t[i], lo_t[i]);
      rd(`ANSC_OFS_ADV);
      chk(rd_val, adv_t[i], "strap advertisement");
      rd(`ANSC_OFS_STATUS);
      chk(rd_val & (st_t[i][9] ? 16'h0200 : 16'h0206), st_t[i], "strap status");
      rd(`ANSC_OFS_CTRL);
      chk(rd_val, `ANSC_CTRL_RESET, "control after straps");
      n = 0;
      repeat (20) begin
        @(negedge ref_clk);
        n += int'(burst_send === 1'b1);
      end
      @(posedge ref_clk);
      chk(16'(n > 0), 16'(st_t[i][9]), "bursts");
      if (!st_t[i][9]) chk({14'h0, speed_100, full_duplex}, {14'h0, ~st_t[i][1], st_t[i][2]}, "forced");
      hi_pins <= ~hi_pins;
      lo_pins <= ~lo_pins;
      repeat (6) @(posedge ref_clk);
      rd(`ANSC_OFS_ADV);
      chk(rd_val, adv_t[i], "straps after reset");
    end
  endtask
  task automatic t_adv_write();
    for (int j = 0; j < 16; j++) begin
      wr(`ANSC_OFS_ADV, {7'h7f, 4'(j), 5'h00});
      rd(`ANSC_OFS_ADV);
      chk(rd_val, {7'h00, 4'(j), 5'h01}, "advertisement write");
    end
    wr(`ANSC_OFS_STATUS, 16'h0000);
    rd(`ANSC_OFS_STATUS);
    chk(rd_val & 16'h0200, 16'h0200, "status is read only");
    rd(8'h3c);
    chk(rd_val, 16'h0000, "unmapped read");
  endtask
  task automatic t_resolve();
    logic [15:0] pw[4] = '{16'h01e1, 16'h00e1, 16'h0061, 16'h0021};
    logic [1:0] e;
    restart_dut(1, 1);
    cfg_on <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      e = 2'(3 - i);
      cfg_link <= 1'b0;
      cfg_word <= pw[i];
      cfg_lag <= 4'(i * 4);
      @(posedge ref_clk);
      cfg_link <= 1'b1;
      wait_done();
      chk({14'h0, speed_100, full_duplex}, {14'h0, e}, "resolved mode");
      chk(heard_word, 16'h01e1, "word heard");
      rd(`ANSC_OFS_STATUS);
      chk(rd_val & 16'h0016, {11'h0, 2'b10, e[0], ~e[1], 1'b0}, "done status");
    end
    cfg_link <= 1'b0;
    cfg_word <= 16'h0061;
    wr(`ANSC_OFS_ADV, 16'h0080);
    cfg_link <= 1'b1;
    repeat (40) @(posedge ref_clk);
    rd(`ANSC_OFS_STATUS);
    chk(rd_val & 16'h0010, 16'h0000, "no common ability");
    wr(`ANSC_OFS_ADV, 16'h0020);
    @(posedge ref_clk);
    wr(`ANSC_OFS_CTRL, 16'h1200);
    wait_done();
    chk({14'h0, speed_100, full_duplex}, 16'h0000, "after restart");
    rd(`ANSC_OFS_CTRL);
    chk(rd_val & 16'h3300, 16'h1000, "control readback");
  endtask
  task automatic t_force();
    cfg_on <= 1'b0;
    for (int k = 3; k >= 0; k--) begin
      wr(`ANSC_OFS_CTRL, 16'h1000);
      @(posedge ref_clk);
      wr(`ANSC_OFS_CTRL, {2'b00, k[1], 4'h0, k[0], 8'h00});
      repeat (3) @(posedge ref_clk);
      chk({14'h0, speed_100, full_duplex}, 16'(k), "forced by control");
      rd(`ANSC_OFS_STATUS);
      chk(rd_val & 16'h0006, {13'h0, k[0], ~k[1], 1'b0}, "forced status");
    end
    wr(`ANSC_OFS_CTRL, 16'h3100);
    rd(`ANSC_OFS_CTRL);
    chk(rd_val, 16'h3100, "control write readback");
    repeat (3) @(posedge ref_clk);
    chk(16'({speed_100, full_duplex} == 2'b11), 16'h0000, "speed bits while enabled");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, hi_pins, lo_pins} = '0;
    {cfg_on, cfg_link, cfg_word, cfg_lag} = '0;
    n_fail = 0;
    comparisons = 0;
    @(posedge ref_clk);
    t_straps();
    t_adv_write();
    t_resolve();
    t_force();
    test_done();
  end
  // Whole run is under a thousand cycles; this allows 40000, over forty times that
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end
endmodule
